// file: sfr_pkg_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------
package sfr_pkg;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_OUTPUT_READ = 8'h3B;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ = 8'h6B;
  // Continuous-read-mode reset code; value arbitrary
  localparam logic [7:0] CMD_CONT_RESET = 8'hFF;

  localparam int ADDR_BITS = 24;
  localparam logic [4:0] CMD_CLKS_X1 = 5'h08;
  localparam logic [4:0] CMD_CLKS_X4 = 5'h02;
  localparam logic [4:0] ADDR_CLKS_X1 = 5'h18;
  localparam logic [4:0] ADDR_CLKS_X2 = 5'h0C;
  localparam logic [4:0] ADDR_CLKS_X4 = 5'h06;
  localparam logic [4:0] MODE_CLKS = 5'h04;
  localparam logic [1:0] CONT_MODE_KEY = 2'h2;

  localparam logic [4:0] DUMMY_NONE = 5'h00;
  localparam logic [4:0] DUMMY_BYTE_X1 = 5'h08;
  localparam logic [4:0] DUMMY_DUAL_IO_SHORT = 5'h04;
  localparam logic [4:0] DUMMY_DUAL_IO_LONG = 5'h08;
  localparam logic [4:0] DUMMY_QPI_4 = 5'h04;
  localparam logic [4:0] DUMMY_QPI_6 = 5'h06;
  localparam logic [4:0] DUMMY_QPI_8 = 5'h08;
  localparam logic [1:0] RP_DUMMY_6 = 2'h2;
  localparam logic [1:0] RP_DUMMY_8 = 2'h3;

  localparam logic [3:0] BEATS_X1 = 4'h8;
  localparam logic [3:0] BEATS_X2 = 4'h4;
  localparam logic [3:0] BEATS_X4 = 4'h2;
  localparam logic [3:0] OE_X1 = 4'h2;
  localparam logic [3:0] OE_X2 = 4'h3;
  localparam logic [3:0] OE_X4 = 4'hF;

  typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} sfr_lane_t;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfr_state_t;
endpackage

// ----------------------------------------------------------------
// Two-stage level synchroniser
// ----------------------------------------------------------------
module sfr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds the second stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: sfr_read_engine.sv
`timescale 1ns/1ns
// Notes on behaviour
// R01: Read 03h takes command and address on rising edges, drives data on falling edges.
// R02: Byte address steps after each output byte and wraps to zero at the top.
// R03: Host drops select, sends code and 3-byte address, may end any time.
// R04: Fast read 0Bh takes one dummy byte after the address before data.
// R05: While busy, fast, dual, dual-I/O and quad reads are refused.
// R06: In four-wire command mode fast read uses 4, 6 or 8 dummy clocks.
// R07: Dual-output read 3Bh: serial address, 8 dummy clocks, data on lines 1,0.
// R08: Dual-I/O read: address two bits per clock, dummy period, two-bit data.
// R09: Mode bits 5-4 equal to 10 make next frame start at the address.
// R10: Other mode bits, or the mode reset code, require a full command next.
// R11: Dual-I/O dummy length follows the dummy-count select bit.
// R12: Dual-I/O uses 4 dummy clocks when select is 0, 8 when 1.
// R13: Host should send mode bits other than 10 when not streaming reads.
// R14: Host sets the quad-enable bit before a quad-output read.
// R15: Quad-enable is status bit 9, delivered here as a level input.
// R16: Quad-output read 6Bh: serial address, 8 dummy clocks, data on lines 3-0.
// R17: Dual-I/O mode bits come two per clock right after the address.
module sfr_read_engine #(
  parameter int ARRAY_ADDR_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic write_in_progress,
  input wire logic quad_enable_bit,
  input wire logic dummy_count_select,
  input wire logic four_wire_command_mode,
  input wire logic [1:0] read_param_dummy,
  output logic read_active,
  output logic cont_mode_active,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic [ARRAY_ADDR_W-1:0] array_addr,
  input wire logic [7:0] array_rdata
);
  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  logic [5:0] cfg_s;
  logic busy_s;
  logic qe_s;
  logic dc_s;
  logic qpi_s;
  logic [1:0] rp_s;
  logic [1:0] back_s;
  logic frame_rst;
  logic data_q;
  logic cont_q;

  // Control levels are quasi-static, so a per-bit synchroniser is enough
  sfr_sync #(
    .WIDTH(6)
  ) u_cfg_sync (
    .clk(sclk),
    .rst(rst),
    .d({write_in_progress, quad_enable_bit, dummy_count_select,
        four_wire_command_mode, read_param_dummy}),
    .q(cfg_s)
  );

  assign busy_s = cfg_s[5];
  assign qe_s = cfg_s[4];
  assign dc_s = cfg_s[3];
  assign qpi_s = cfg_s[2];
  assign rp_s = cfg_s[1:0];

  sfr_sync #(
    .WIDTH(2)
  ) u_back_sync (
    .clk(clk),
    .rst(rst),
    .d({data_q, cont_q}),
    .q(back_s)
  );

  assign read_active = back_s[1];
  assign cont_mode_active = back_s[0];

  // Select high ends the frame at once; the link clock may be stopped then
  assign frame_rst = rst | cs_n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input sfr_pkg::sfr_lane_t w);
    logic [23:0] r;
    r = {sh[22:0], io[0]};
    if (w == sfr_pkg::LANE_X2) begin
      r = {sh[21:0], io[1:0]};
    end else if (w == sfr_pkg::LANE_X4) begin
      r = {sh[19:0], io[3:0]};
    end
    return r;
  endfunction

  function automatic logic [3:0] beats_of(input sfr_pkg::sfr_lane_t w);
    logic [3:0] r;
    r = sfr_pkg::BEATS_X1;
    if (w == sfr_pkg::LANE_X2) begin
      r = sfr_pkg::BEATS_X2;
    end else if (w == sfr_pkg::LANE_X4) begin
      r = sfr_pkg::BEATS_X4;
    end
    return r;
  endfunction

  function automatic logic [4:0] addr_clks(input sfr_pkg::sfr_lane_t w);
    logic [4:0] r;
    r = sfr_pkg::ADDR_CLKS_X1;
    if (w == sfr_pkg::LANE_X2) begin
      r = sfr_pkg::ADDR_CLKS_X2;
    end else if (w == sfr_pkg::LANE_X4) begin
      r = sfr_pkg::ADDR_CLKS_X4;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Command, address and dummy sequencing (rising edge)
  // ----------------------------------------------------------------
  sfr_pkg::sfr_state_t state_q;
  sfr_pkg::sfr_lane_t in_w_q;
  sfr_pkg::sfr_lane_t out_w_q;
  sfr_pkg::sfr_lane_t in_lane;
  logic [4:0] cnt_q;
  logic [4:0] dummy_q;
  logic [23:0] sh_q;
  logic [23:0] shifted;
  logic [7:0] code;
  logic [4:0] cmd_last;
  logic [4:0] qpi_dummy;
  logic dual_io_q;
  logic [3:0] beat_q;
  logic cmd_done;
  logic addr_done;
  logic mode_done;

  // Four-wire mode takes the code itself a nibble per clock
  assign in_lane = (state_q == sfr_pkg::ST_CMD && qpi_s) ? sfr_pkg::LANE_X4 : in_w_q;
  assign shifted = shift_in(sh_q, io_in, in_lane);
  assign code = shifted[7:0];
  assign cmd_last = qpi_s ? sfr_pkg::CMD_CLKS_X4 - 5'h01 : sfr_pkg::CMD_CLKS_X1 - 5'h01;
  assign cmd_done = (state_q == sfr_pkg::ST_CMD) && (cnt_q == cmd_last);
  assign addr_done = (state_q == sfr_pkg::ST_ADDR) && (cnt_q == addr_clks(in_w_q) - 5'h01);
  // R17 mode bits
  assign mode_done = (state_q == sfr_pkg::ST_DUMMY) && dual_io_q &&
                     (cnt_q == sfr_pkg::MODE_CLKS - 5'h01);

  // R06 dummy field
  always_comb begin
    qpi_dummy = sfr_pkg::DUMMY_QPI_4;
    if (rp_s == sfr_pkg::RP_DUMMY_6) begin
      qpi_dummy = sfr_pkg::DUMMY_QPI_6;
    end else if (rp_s == sfr_pkg::RP_DUMMY_8) begin
      qpi_dummy = sfr_pkg::DUMMY_QPI_8;
    end
  end

  // R01 rising-edge sampling
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      state_q <= sfr_pkg::ST_CMD;
      cnt_q <= '0;
      sh_q <= '0;
      in_w_q <= sfr_pkg::LANE_X1;
      out_w_q <= sfr_pkg::LANE_X1;
      dummy_q <= sfr_pkg::DUMMY_NONE;
      dual_io_q <= 1'b0;
    end else begin
      unique case (state_q)
        sfr_pkg::ST_CMD: begin
          if (cnt_q == 5'h00 && cont_q && !qpi_s) begin
            // R09 address-first frame
            if (busy_s) begin
              state_q <= sfr_pkg::ST_IGNORE;
            end else begin
              state_q <= sfr_pkg::ST_ADDR;
              cnt_q <= 5'h01;
              sh_q <= {sh_q[21:0], io_in[1:0]};
              in_w_q <= sfr_pkg::LANE_X2;
              out_w_q <= sfr_pkg::LANE_X2;
              dual_io_q <= 1'b1;
              // R11 R12 dummy length
              dummy_q <= dc_s ? sfr_pkg::DUMMY_DUAL_IO_LONG : sfr_pkg::DUMMY_DUAL_IO_SHORT;
            end
          end else if (cmd_done) begin
            cnt_q <= '0;
            state_q <= sfr_pkg::ST_IGNORE;
            if (code == sfr_pkg::CMD_READ && !qpi_s) begin
              state_q <= sfr_pkg::ST_ADDR;
              dummy_q <= sfr_pkg::DUMMY_NONE;
            end else if (code == sfr_pkg::CMD_FAST_READ && !busy_s) begin
              // R04 R06 fast read
              state_q <= sfr_pkg::ST_ADDR;
              dummy_q <= qpi_s ? qpi_dummy : sfr_pkg::DUMMY_BYTE_X1;
              in_w_q <= qpi_s ? sfr_pkg::LANE_X4 : sfr_pkg::LANE_X1;
              out_w_q <= qpi_s ? sfr_pkg::LANE_X4 : sfr_pkg::LANE_X1;
            end else if (code == sfr_pkg::CMD_DUAL_OUTPUT_READ && !busy_s && !qpi_s) begin
              // R07 dual output
              state_q <= sfr_pkg::ST_ADDR;
              dummy_q <= sfr_pkg::DUMMY_BYTE_X1;
              out_w_q <= sfr_pkg::LANE_X2;
            end else if (code == sfr_pkg::CMD_DUAL_IO_READ && !busy_s && !qpi_s) begin
              // R08 R11 R12 dual I/O
              state_q <= sfr_pkg::ST_ADDR;
              dummy_q <= dc_s ? sfr_pkg::DUMMY_DUAL_IO_LONG : sfr_pkg::DUMMY_DUAL_IO_SHORT;
              in_w_q <= sfr_pkg::LANE_X2;
              out_w_q <= sfr_pkg::LANE_X2;
              dual_io_q <= 1'b1;
            end else if (code == sfr_pkg::CMD_QUAD_OUTPUT_READ && !busy_s && !qpi_s &&
                         qe_s) begin
              // R16 R15 quad output
              state_q <= sfr_pkg::ST_ADDR;
              dummy_q <= sfr_pkg::DUMMY_BYTE_X1;
              out_w_q <= sfr_pkg::LANE_X4;
            end
            // R05 busy refusal falls through to the ignore state
          end else begin
            cnt_q <= cnt_q + 5'h01;
            sh_q <= shifted;
          end
        end
        sfr_pkg::ST_ADDR: begin
          sh_q <= shifted;
          cnt_q <= addr_done ? 5'h00 : cnt_q + 5'h01;
          if (addr_done) begin
            state_q <= (dummy_q == sfr_pkg::DUMMY_NONE) ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
          end
        end
        sfr_pkg::ST_DUMMY: begin
          sh_q <= shifted;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == dummy_q - 5'h01) begin
            state_q <= sfr_pkg::ST_DATA;
          end
        end
        sfr_pkg::ST_DATA: begin
          cnt_q <= '0;
        end
        sfr_pkg::ST_IGNORE: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Continuous-read mode flag; survives the frame, cleared by reset
  // ----------------------------------------------------------------
  logic [7:0] lead_q;
  logic [4:0] lead_cnt_q;
  logic lead_done;

  // Line 0 is watched on its own, so the reset code is heard in an address-first frame
  assign lead_done = (lead_cnt_q == sfr_pkg::CMD_CLKS_X1 - 5'h01);

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      lead_q <= '0;
      lead_cnt_q <= '0;
    end else if (lead_cnt_q != sfr_pkg::CMD_CLKS_X1) begin
      lead_q <= {lead_q[6:0], io_in[0]};
      lead_cnt_q <= lead_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cont_q <= 1'b0;
    end else if (mode_done) begin
      // R09 R10 mode bits
      cont_q <= (shifted[5:4] == sfr_pkg::CONT_MODE_KEY);
    end else if (lead_done && !qpi_s &&
                 {lead_q[6:0], io_in[0]} == sfr_pkg::CMD_CONT_RESET) begin
      // R10 mode reset code
      cont_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Array address and beat counting
  // ----------------------------------------------------------------
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      array_addr <= '0;
      beat_q <= '0;
      data_q <= 1'b0;
    end else begin
      data_q <= (state_q == sfr_pkg::ST_DATA) ||
                (addr_done && dummy_q == sfr_pkg::DUMMY_NONE) ||
                (state_q == sfr_pkg::ST_DUMMY && cnt_q == dummy_q - 5'h01);
      if (addr_done) begin
        array_addr <= shifted[ARRAY_ADDR_W-1:0];
      end else if (state_q == sfr_pkg::ST_DATA) begin
        if (beat_q == beats_of(out_w_q) - 4'h1) begin
          beat_q <= '0;
          // R02 increment and wrap
          array_addr <= array_addr + 1'b1;
        end else begin
          beat_q <= beat_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shifter (falling edge)
  // ----------------------------------------------------------------
  logic [7:0] out_sh_q;
  logic [7:0] cur;

  assign cur = (beat_q == 4'h0) ? array_rdata : out_sh_q;

  // R01 falling-edge data
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_sh_q <= '0;
      io_out <= '0;
      io_oe <= '0;
    end else if (state_q == sfr_pkg::ST_DATA) begin
      unique case (out_w_q)
        sfr_pkg::LANE_X1: begin
          io_out <= {2'h0, cur[7], 1'b0};
          io_oe <= sfr_pkg::OE_X1;
          out_sh_q <= {cur[6:0], 1'b0};
        end
        sfr_pkg::LANE_X2: begin
          // R07 R08 two lanes
          io_out <= {2'h0, cur[7:6]};
          io_oe <= sfr_pkg::OE_X2;
          out_sh_q <= {cur[5:0], 2'h0};
        end
        sfr_pkg::LANE_X4: begin
          // R16 four lanes
          io_out <= cur[7:4];
          io_oe <= sfr_pkg::OE_X4;
          out_sh_q <= {cur[3:0], 4'h0};
        end
        default: begin
          io_out <= '0;
          io_oe <= '0;
        end
      endcase
    end else begin
      io_out <= '0;
      io_oe <= '0;
    end
  end
endmodule

// file: sfr_read_engine_monitor.sv
`timescale 1ns/1ns
module sfr_read_engine_monitor #(
  parameter int ARRAY_ADDR_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic write_in_progress,
  input wire logic four_wire_command_mode,
  input wire logic read_active,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [ARRAY_ADDR_W-1:0] array_addr,
  input wire logic [7:0] array_rdata
);
  // ----------------
  // Link checks
  // ----------------
  // deselect idles
  property p_idle;
    @(posedge clk) disable iff (rst) cs_n |-> io_oe == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("oe while deselected");
  property p_busy;
    @(posedge sclk) disable iff (rst) $rose(io_oe != 4'h0) |-> !write_in_progress || io_oe == 4'h2;
  endproperty
  a_busy: assert property (p_busy) else $error("read while busy");
  property p_fw;
    @(posedge sclk) disable iff (rst) four_wire_command_mode && io_oe != 4'h0 |-> io_oe == 4'hF;
  endproperty
  a_fw: assert property (p_fw) else $error("lane width");
  property p_x1;
    @(posedge sclk) disable iff (rst) $rose(io_oe == 4'h2) |-> io_out[1] == array_rdata[7];
  endproperty
  a_x1: assert property (p_x1) else $error("x1 first beat");
  property p_x2;
    @(posedge sclk) disable iff (rst) $rose(io_oe == 4'h3) |-> io_out[1:0] == array_rdata[7:6];
  endproperty
  a_x2: assert property (p_x2) else $error("x2 first beat");
  property p_x4;
    @(posedge sclk) disable iff (rst) $rose(io_oe == 4'hF) |-> io_out == array_rdata[7:4];
  endproperty
  a_x4: assert property (p_x4) else $error("x4 first beat");
  property p_step;
    @(posedge sclk) disable iff (rst) io_oe != 4'h0 && $past(io_oe) != 4'h0 &&
      $changed(array_addr) |-> array_addr == $past(array_addr) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("address step");
  property p_ra;
    @(posedge clk) disable iff (rst) $rose(io_oe != 4'h0) |-> ##[1:6] read_active;
  endproperty
  a_ra: assert property (p_ra) else $error("read_active late");
endmodule

bind sfr_read_engine sfr_read_engine_monitor #(.ARRAY_ADDR_W(ARRAY_ADDR_W)) i_mon (
  .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .write_in_progress(write_in_progress),
  .four_wire_command_mode(four_wire_command_mode), .read_active(read_active),
  .io_out(io_out), .io_oe(io_oe), .array_addr(array_addr), .array_rdata(array_rdata)
);

// file: sfr_host_model.sv
`timescale 1ns/1ns
module sfr_host_model (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_drv,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] pat = 4'h5;
  logic [3:0] oe_seen = 4'h0;
  logic [7:0] got[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_drv = 4'h0;
  end
  // ----------------
  // Host steps
  // ----------------
  // drive after fall, sample at rise; unused lines toggle, never hold
  task automatic tick(input logic [3:0] v, input logic [3:0] m, output logic [3:0] s);
    io_drv = (v & m) | (pat & ~m);
    pat = ~pat;
    #7 sclk = 1'b1;
    s = io_out;
    oe_seen = oe_seen | io_oe;
    #8 sclk = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] s;
    for (int i = n - 1; i >= 0; i--) begin
      tick(4'(v >> (i * w)), 4'((1 << w) - 1), s);
    end
  endtask
  task automatic recv(input int w, input int nb);
    logic [3:0] s;
    logic [7:0] b;
    for (int k = 0; k < nb; k++) begin
      for (int j = 0; j < 8 / w; j++) begin
        tick(4'h0, 4'h0, s);
        b = w == 1 ? {b[6:0], s[1]} : w == 2 ? {b[5:0], s[1:0]} : {b[3:0], s};
      end
      got.push_back(b);
    end
  endtask
  task automatic frame(input logic [7:0] c, input int cw, input int aw, input logic [23:0] a,
    input logic [7:0] md, input int dm, input int w, input int nb);
    logic [3:0] s;
    repeat (3) tick(4'h0, 4'h0, s);
    oe_seen = 4'h0;
    got.delete();
    cs_n = 1'b0;
    if (cw != 0) send(32'(c), 8 / cw, cw);
    if (aw != 0) send(32'(a), 24 / aw, aw);
    // mode bits open the dual-I/O dummy period
    if (aw == 2) send(32'(md), 4, 2);
    send(32'h0, dm, aw == 0 ? 1 : aw);
    recv(w, nb);
    cs_n = 1'b1;
  endtask
endmodule

// file: sfr_read_engine_tb.sv
`timescale 1ns/1ns
module sfr_read_engine_tb;
  logic clk;
  logic rst;
  logic write_in_progress;
  logic quad_enable_bit;
  logic dummy_count_select;
  logic four_wire_command_mode;
  logic [1:0] read_param_dummy;
  logic read_active;
  logic cont_mode_active;
  logic sclk;
  logic cs_n;
  logic [3:0] io_drv;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [23:0] array_addr;
  logic [7:0] array_rdata;
  int n_errors;
  int checked;
  int seed;
  int cont;
  logic [7:0] cm [5] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'h03};
  int aw [5] = '{1, 1, 2, 1, 1};
  int dm [5] = '{8, 8, 0, 8, 0};
  int wd [5] = '{1, 2, 2, 4, 1};
  wire [3:0] io_in = (io_oe & io_out) | (~io_oe & io_drv);
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction
  function automatic logic [23:0] rnd();
    return 24'($random(seed));
  endfunction
  assign array_rdata = mem(array_addr);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sfr_read_engine i_sfr_read_engine (
    .clk(clk), .rst(rst), .write_in_progress(write_in_progress),
    .quad_enable_bit(quad_enable_bit), .dummy_count_select(dummy_count_select),
    .four_wire_command_mode(four_wire_command_mode), .read_param_dummy(read_param_dummy),
    .read_active(read_active), .cont_mode_active(cont_mode_active), .sclk(sclk),
    .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .array_addr(array_addr), .array_rdata(array_rdata)
  );
  sfr_host_model i_sfr_host_model (
    .sclk(sclk), .cs_n(cs_n), .io_drv(io_drv), .io_out(io_out), .io_oe(io_oe)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------
  // One read frame against the reference model
  // ----------------
  task automatic rd(input logic [7:0] c, input int cw, input int a_w, input logic [23:0] a,
    input logic [7:0] md, input int dmy, input int w);
    logic ok;
    logic [3:0] ex;
    @(posedge clk);
    #2;
    ok = !(write_in_progress && c != sfr_pkg::CMD_READ) &&
      !(c == sfr_pkg::CMD_QUAD_OUTPUT_READ && !quad_enable_bit);
    ex = !ok ? 4'h0 : w == 1 ? sfr_pkg::OE_X1 : w == 2 ? sfr_pkg::OE_X2 : sfr_pkg::OE_X4;
    i_sfr_host_model.frame(c, cw, a_w, a, md, dmy, w, 3);
    check(i_sfr_host_model.oe_seen, ex);
    for (int i = 0; i < 3 && ok; i++) begin
      check(i_sfr_host_model.got[i], mem(a + 24'(i)));
    end
    if (ok && a_w == 2) cont = int'(md[5:4] == sfr_pkg::CONT_MODE_KEY);
    repeat (6) @(posedge clk);
    check(cont_mode_active, cont);
    $display("test done: cmd %h lanes %0d", c, w);
  endtask
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
  initial begin
    seed = 32'h8361;
    cont = 0;
    n_errors = 0;
    checked = 0;
    rst = 1'b1;
    write_in_progress = 1'b0;
    quad_enable_bit = 1'b1;
    dummy_count_select = 1'b0;
    four_wire_command_mode = 1'b0;
    read_param_dummy = 2'h0;
    fork
      repeat (5) @(posedge clk);
      i_sfr_host_model.send(32'h0, 3, 1);
    join
    @(posedge clk) rst <= 1'b0;
    // mode bits kept off the key unless streaming
    for (int b = 0; b < 2; b++) begin
      @(posedge clk) write_in_progress <= b[0];
      for (int i = 0; i < 5; i++) begin
        rd(cm[i], 1, aw[i], rnd(), 8'h00, dm[i], wd[i]);
      end
    end
    @(posedge clk) write_in_progress <= 1'b0;
    rd(sfr_pkg::CMD_READ, 1, 1, 24'hFFFFFE, 8'h00, 0, 1);
    // quad read without the enable is refused
    @(posedge clk) quad_enable_bit <= 1'b0;
    rd(sfr_pkg::CMD_QUAD_OUTPUT_READ, 1, 1, rnd(), 8'h00, 8, 4);
    for (int d = 0; d < 2; d++) begin
      @(posedge clk) dummy_count_select <= d[0];
      rd(sfr_pkg::CMD_DUAL_IO_READ, 1, 2, rnd(), 8'h00, 4 * d, 2);
    end
    rd(sfr_pkg::CMD_DUAL_IO_READ, 1, 2, rnd(), 8'h20, 4, 2);
    rd(sfr_pkg::CMD_DUAL_IO_READ, 0, 2, rnd(), 8'h00, 4, 2);
    rd(sfr_pkg::CMD_DUAL_IO_READ, 1, 2, rnd(), 8'h20, 4, 2);
    i_sfr_host_model.frame(sfr_pkg::CMD_CONT_RESET, 1, 0, 24'h0, 8'h00, 0, 1, 0);
    cont = 0;
    rd(sfr_pkg::CMD_READ, 1, 1, rnd(), 8'h00, 0, 1);
    @(posedge clk) four_wire_command_mode <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge clk) read_param_dummy <= 2'(p);
      rd(sfr_pkg::CMD_FAST_READ, 4, 4, rnd(), 8'h00, p < 2 ? 4 : 2 * p + 2, 4);
    end
    end_sim();
  end
endmodule
